// [src/pmc_top.sv]
/*
   Programmable memory controller: bank decode, simple chip-select machine
   and one programmable sequencer driven from a 64-word pattern store.
   Assumes one 100 MHz clock; quarter-clock phase vectors are serialised
   by an output stage outside this block. Config inputs are held stable.
*/
// Function
// - after reset bank zero selects everything, boot port size from pins
// - machine field 00 runs the bank with the simple chip-select machine
// - port field 01 means 8-bit port, 00 means 32-bit; beats sized to match
// - machine field 10 runs the bank with programmable sequencer A
// - 17-bit base compared with upper address bits, 32K boundaries
// - 17-bit mask sets bank size from 32K to 4G
// - write to a write-protected bank does not match it
// - with bus monitor on, an unmatched access raises transfer error ack
// - select edges placed at quarter-clock resolution
// - one word per clock: four chip-select phases, four byte-select phases
// - general-purpose lines taken from word bits 8 to 21
// - bits 24..31: loop, exception, mux pair, next, ack, precharge, last
// - loop bit repeats a word for a programmed count
// - exception exits only at a word with exception enable set
// - mux bits pick row/column address; next-address bit increments address
// - ack control bit sets where transfer ack is generated
// - precharge bit starts disable timer blocking the bank
// - pattern store holds 64 words of 32 bits
// - six entry points by cycle type; burst read at 08H
// - one word per clock, stop after the word marked last
// - single read enters at 18H
// - no chip select on a bank before its valid bit is set, except boot bank zero and refresh cycles
// - simple machine inserts the four-bit wait-state count
`include "pmc_params.svh"

module pmc_top #(
   parameter int NB = `PMC_NUM_BANKS,
   parameter int DEPTH = `PMC_PAT_DEPTH
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic acc_req_in,
   input wire pmc_pkg::pmc_addr_t acc_addr_in,
   input wire logic acc_write_in,
   input wire logic acc_burst_in,
   input wire logic refresh_req_in,
   input wire logic [$clog2(NB)-1:0] refresh_bank_in,
   input wire logic exception_in,
   input wire logic [1:0] boot_port_size_in,
   input wire logic boot_reprog_in,
   input wire logic bus_monitor_en_in,
   input wire logic [NB*`PMC_BASE_W-1:0] bank_base_in,
   input wire logic [NB*`PMC_BASE_W-1:0] bank_size_mask_in,
   input wire logic [NB-1:0] bank_valid_in,
   input wire logic [NB-1:0] bank_write_protect_in,
   input wire logic [NB*2-1:0] machine_select_field_in,
   input wire logic [NB*2-1:0] port_size_field_in,
   input wire logic [NB*4-1:0] wait_state_count_in,
   input wire logic [3:0] loop_count_in,
   input wire logic [7:0] precharge_cycles_in,
   input wire logic pat_we_in,
   input wire pmc_pkg::pmc_pat_addr_t pat_addr_in,
   input wire logic [31:0] pat_data_in,
   output logic acc_ready_out,
   output logic acc_done_out,
   output logic [NB*4-1:0] select_phase_bits_n_out,
   output logic [15:0] byte_select_lines_n_out,
   output logic [`PMC_W_GPL_W-1:0] gp_lines_out,
   output logic [1:0] row_col_mux_select_out,
   output pmc_pkg::pmc_addr_t mem_addr_out,
   output logic port8_out,
   output logic transfer_ack_out,
   output logic transfer_error_ack_out
);
   import pmc_pkg::*;

   localparam int BW = `PMC_BASE_W;
   localparam int IW = $clog2(NB);

   // ======================================================================
   // state
   pmc_state_t state_q, state_d;
   logic [IW-1:0] bank_q;
   logic [1:0] ps_q;
   logic [3:0] wait_q;
   logic [3:0] wcnt_q;
   logic [1:0] beat_q;
   pmc_pat_addr_t pc_q;
   logic [3:0] loop_cnt_q;
   logic exc_pend_q;
   logic [7:0] pre_cnt_q;
   logic [IW-1:0] pre_bank_q;
   logic boot_q;
   logic boot_cap_q;
   logic end_q;
   logic [1:0] boot_ps_q;
   pmc_addr_t addr_q;
   logic [31:0] pat_mem [DEPTH];

   // ======================================================================
   // bank decode
   logic [NB-1:0] bank_hit;
   logic [IW-1:0] hit_idx;
   logic hit_any;

   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_hit
         assign bank_hit[g] = bank_valid_in[g]
            && !(bank_write_protect_in[g] && acc_write_in)
            && (((acc_addr_in[31:15] ^ bank_base_in[g*BW +: BW])
                 & bank_size_mask_in[g*BW +: BW]) == '0);
      end
   endgenerate

   always_comb begin
      hit_idx = '0;
      hit_any = 1'b0;
      for (int i = NB - 1; i >= 0; i--) begin
         if (bank_hit[i]) begin
            hit_idx = IW'(i);
            hit_any = 1'b1;
         end
      end
   end

   // boot bank claims every address until reprogrammed
   wire [IW-1:0] sel_idx = boot_q ? '0 : hit_idx;
   wire sel_any = boot_q || hit_any;
   wire [1:0] sel_ms = boot_q ? `PMC_MS_SIMPLE : machine_select_field_in[sel_idx*2 +: 2];
   wire [1:0] sel_ps = boot_q ? boot_ps_q : port_size_field_in[sel_idx*2 +: 2];
   wire [3:0] sel_wait = wait_state_count_in[sel_idx*4 +: 4];
   wire sel_ok = sel_ms == `PMC_MS_SIMPLE || sel_ms == `PMC_MS_SEQ_A;
   // bank held off while its disable timer runs
   wire sel_blocked = pre_cnt_q != 8'h00 && pre_bank_q == sel_idx;
   wire ref_blocked = pre_cnt_q != 8'h00 && pre_bank_q == refresh_bank_in;
   wire idle = state_q == ST_IDLE;
   wire take = idle && boot_cap_q && acc_req_in && sel_any && sel_ok && !sel_blocked;
   wire miss = idle && boot_cap_q && acc_req_in && !(sel_any && sel_ok);
   wire ref_take = idle && boot_cap_q && !acc_req_in && refresh_req_in && !ref_blocked;
   wire take_simple = take && sel_ms == `PMC_MS_SIMPLE;
   wire take_seq = (take && sel_ms == `PMC_MS_SEQ_A) || ref_take;

   wire [5:0] ent_acc = acc_write_in
      ? (acc_burst_in ? `PMC_ENT_BURST_WR : `PMC_ENT_SINGLE_WR)
      : (acc_burst_in ? `PMC_ENT_BURST_RD : `PMC_ENT_SINGLE_RD);
   wire [5:0] entry = ref_take ? `PMC_ENT_TIMER : ent_acc;

   // ======================================================================
   // sequencer word fields
   // word layout
   wire [31:0] w = pat_mem[pc_q];
   wire [3:0] w_cst = w[`PMC_W_CST_LSB +: 4];
   wire [3:0] w_bst = w[`PMC_W_BST_LSB +: 4];
   wire [`PMC_W_GPL_W-1:0] w_gpl = w[`PMC_W_GPL_LSB +: `PMC_W_GPL_W];
   wire w_loop = w[`PMC_W_LOOP];
   wire w_exception_exit_enable = w[`PMC_W_EXCEPTION_EXIT_ENABLE];
   wire [1:0] w_amx = w[`PMC_W_AMX_LSB +: 2];
   wire w_na = w[`PMC_W_NA];
   wire w_uta = w[`PMC_W_UTA];
   wire w_precharge_timer_trigger = w[`PMC_W_PRECHARGE_TIMER_TRIGGER];
   wire w_last = w[`PMC_W_LAST];
   wire in_seq = state_q == ST_SEQ;
   // exception leaves only at an enabled word
   wire exc_exit = in_seq && exc_pend_q && w_exception_exit_enable;
   // repeat word until the loop count is reached
   wire loop_hold = w_loop && loop_cnt_q != loop_count_in;
   // a looping last word only ends once its repeats are spent
   wire seq_end = in_seq && !exc_exit && w_last && !loop_hold;

   // beat count and address step follow port size
   wire [1:0] last_beat = ps_q == `PMC_PS_8 ? 2'h3 : (ps_q == `PMC_PS_16 ? 2'h1 : 2'h0);
   wire [31:0] step = ps_q == `PMC_PS_8 ? 32'h1 : (ps_q == `PMC_PS_16 ? 32'h2 : 32'h4);
   wire [3:0] lanes = ps_q == `PMC_PS_8 ? 4'h1 : (ps_q == `PMC_PS_16 ? 4'h3 : 4'hF);
   wire in_simple = state_q == ST_SIMPLE;
   wire beat_done = in_simple && wcnt_q == 4'h0;
   wire simple_end = beat_done && beat_q == last_beat;

   // ======================================================================
   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (take_simple) begin
               state_d = ST_SIMPLE;
            end else if (take_seq) begin
               state_d = ST_SEQ;
            end
         end
         ST_SIMPLE: begin
            if (simple_end) begin
               state_d = ST_IDLE;
            end
         end
         ST_SEQ: begin
            if (seq_end) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // ======================================================================
   // select and byte-lane phase vectors, active low
   logic [NB*4-1:0] cs_d;
   logic [15:0] bs_d;
   always_comb begin
      cs_d = '1;
      bs_d = '1;
      // simple machine holds select low for the whole beat
      if (in_simple) begin
         cs_d[bank_q*4 +: 4] = 4'h0;
      end
      // sequencer places edges per quarter phase
      if (in_seq) begin
         cs_d[bank_q*4 +: 4] = w_cst;
      end
      for (int l = 0; l < 4; l++) begin
         if (lanes[l]) begin
            bs_d[l*4 +: 4] = in_seq ? w_bst : (in_simple ? 4'h0 : 4'hF);
         end
      end
   end

   // ======================================================================
   // pattern store
   // 64 words of 32 bits
   always_ff @(posedge ref_clk_in) begin
      if (pat_we_in) begin
         pat_mem[pat_addr_in] <= pat_data_in;
      end
   end

   // ======================================================================
   // control flops
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         boot_q <= 1'b1;
         boot_cap_q <= 1'b0;
         boot_ps_q <= `PMC_PS_32;
         exc_pend_q <= 1'b0;
         end_q <= 1'b0;
      end else begin
         state_q <= state_d;
         // done follows the cycle that shows the last beat or word
         end_q <= simple_end || seq_end;
         // boot port size is sampled once, on the first edge after release
         boot_cap_q <= 1'b1;
         if (!boot_cap_q) begin
            boot_ps_q <= boot_port_size_in;
         end
         if (boot_reprog_in) begin
            boot_q <= 1'b0;
         end
         // a new exception beats the clear in the same cycle
         exc_pend_q <= (in_seq && exception_in) || (exc_pend_q && !exc_exit && !seq_end);
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bank_q <= '0;
         ps_q <= `PMC_PS_32;
         wait_q <= 4'h0;
         wcnt_q <= 4'h0;
         beat_q <= 2'h0;
         pc_q <= '0;
         loop_cnt_q <= 4'h0;
         addr_q <= '0;
      end else if (idle) begin
         bank_q <= ref_take ? refresh_bank_in : sel_idx;
         ps_q <= ref_take ? `PMC_PS_32 : sel_ps;
         wait_q <= sel_wait;
         wcnt_q <= sel_wait;
         beat_q <= 2'h0;
         pc_q <= entry;
         loop_cnt_q <= 4'h0;
         addr_q <= acc_addr_in;
      end else if (in_simple && beat_done) begin
         wcnt_q <= wait_q;
         beat_q <= beat_q + 2'h1;
         addr_q <= addr_q + step;
      end else if (in_simple) begin
         wcnt_q <= wcnt_q - 4'h1;
      end else if (exc_exit) begin
         pc_q <= `PMC_ENT_EXCEPT;
         loop_cnt_q <= 4'h0;
      end else if (in_seq) begin
         loop_cnt_q <= loop_hold ? loop_cnt_q + 4'h1 : 4'h0;
         pc_q <= loop_hold ? pc_q : pc_q + 1'b1;
         // next-address bit steps the burst address
         if (w_na) begin
            addr_q <= addr_q + step;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pre_cnt_q <= 8'h00;
         pre_bank_q <= '0;
      end else if (in_seq && w_precharge_timer_trigger) begin
         pre_cnt_q <= precharge_cycles_in;
         pre_bank_q <= bank_q;
      end else if (pre_cnt_q != 8'h00) begin
         pre_cnt_q <= pre_cnt_q - 8'h01;
      end
   end

   // ======================================================================
   // registered outputs
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_ready_out <= 1'b0;
         acc_done_out <= 1'b0;
         select_phase_bits_n_out <= '1;
         byte_select_lines_n_out <= '1;
         gp_lines_out <= '1;
         row_col_mux_select_out <= 2'h0;
         mem_addr_out <= '0;
         port8_out <= 1'b0;
         transfer_ack_out <= 1'b0;
         transfer_error_ack_out <= 1'b0;
      end else begin
         acc_ready_out <= state_d == ST_IDLE;
         acc_done_out <= end_q;
         select_phase_bits_n_out <= cs_d;
         byte_select_lines_n_out <= bs_d;
         gp_lines_out <= in_seq ? w_gpl : '1;
         row_col_mux_select_out <= in_seq ? w_amx : 2'h0;
         mem_addr_out <= addr_q;
         port8_out <= ps_q == `PMC_PS_8;
         // a clear ack control bit acknowledges in that clock
         transfer_ack_out <= beat_done || (in_seq && !w_uta);
         transfer_error_ack_out <= miss && bus_monitor_en_in;
      end
   end

endmodule

// [src/pmc_params.svh]
/*
   Constants of the programmable memory controller: bank decode widths,
   field codes, sequencer word layout and sequencer entry points.
   Assumes it is included by its bare name from the package and the top.
*/
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ==========================================================================
// bank decode
`define PMC_NUM_BANKS 8
`define PMC_BASE_W 17
`define PMC_ADDR_W 32
`define PMC_MS_SIMPLE 2'h0
`define PMC_MS_SEQ_A 2'h2
`define PMC_PS_32 2'h0
`define PMC_PS_8 2'h1
`define PMC_PS_16 2'h2

// ==========================================================================
// pattern store, bit 0 of the word is its most significant bit
`define PMC_PAT_DEPTH 64
`define PMC_PAT_AW 6
`define PMC_W_CST_LSB 28
`define PMC_W_BST_LSB 24
`define PMC_W_GPL_LSB 10
`define PMC_W_GPL_W 14
`define PMC_W_LOOP 7
`define PMC_W_EXCEPTION_EXIT_ENABLE 6
`define PMC_W_AMX_LSB 4
`define PMC_W_NA 3
`define PMC_W_UTA 2
`define PMC_W_PRECHARGE_TIMER_TRIGGER 1
`define PMC_W_LAST 0

// ==========================================================================
// sequencer entry points
`define PMC_ENT_BURST_RD 6'h08
`define PMC_ENT_SINGLE_RD 6'h18
`define PMC_ENT_SINGLE_WR 6'h00
`define PMC_ENT_BURST_WR 6'h20
`define PMC_ENT_TIMER 6'h30
`define PMC_ENT_EXCEPT 6'h3C

`endif

// [src/pmc_pkg.sv]
/*
   Types shared by the programmable memory controller.
   Assumes pmc_params.svh is on the include path.
*/
`include "pmc_params.svh"

package pmc_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SIMPLE, ST_SEQ} pmc_state_t;
   typedef logic [`PMC_PAT_AW-1:0] pmc_pat_addr_t;
   typedef logic [`PMC_ADDR_W-1:0] pmc_addr_t;
endpackage

// [dv/pmc_sva.sv]
/* Checker for pmc_top: error ack, done, select gating and take relations.
   Assumes it is bound to every pmc_top instance with that instance's bank count. */
`include "pmc_params.svh"

// ==========================================================================
// checker
module pmc_sva #(
   parameter int NB = `PMC_NUM_BANKS
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic acc_req_in,
   input wire logic refresh_req_in,
   input wire logic bus_monitor_en_in,
   input wire logic [NB-1:0] bank_valid_in,
   input wire logic acc_ready_out,
   input wire logic acc_done_out,
   input wire logic [NB*4-1:0] select_phase_bits_n_out,
   input wire logic [15:0] byte_select_lines_n_out,
   input wire logic [`PMC_W_GPL_W-1:0] gp_lines_out,
   input wire logic port8_out,
   input wire logic transfer_ack_out,
   input wire logic transfer_error_ack_out
);
   logic [NB-1:0] sel_any;
   always_comb begin
      for (int g = 0; g < NB; g++) begin
         sel_any[g] = ~&select_phase_bits_n_out[g*4+:4];
      end
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);
   err_needs_mon_a: assert property (transfer_error_ack_out |-> $past(bus_monitor_en_in))
      else $error("error ack without bus monitor");
   err_needs_req_a: assert property (transfer_error_ack_out |-> $past(acc_req_in))
      else $error("error ack without a request");
   err_no_sel_a: assert property (transfer_error_ack_out |-> &select_phase_bits_n_out)
      else $error("select driven on an unmatched access");
   done_single_a: assert property (acc_done_out |=> !acc_done_out)
      else $error("done longer than one cycle");
   done_quiet_a: assert property (acc_done_out |->
      (&select_phase_bits_n_out && &byte_select_lines_n_out && &gp_lines_out))
      else $error("lines active in the done cycle");
   valid_gate_a: assert property ((sel_any[NB-1:1] & ~bank_valid_in[NB-1:1]) == '0)
      else $error("select on a bank that is not valid");
   take_cause_a: assert property ($fell(acc_ready_out) |->
      ($past(acc_req_in) || $past(refresh_req_in)))
      else $error("busy without any request");
   ack_not_done_a: assert property (transfer_ack_out |-> !acc_done_out)
      else $error("ack in the done cycle");
   cover property (transfer_error_ack_out);
   cover property (transfer_ack_out && port8_out);
   cover property (transfer_ack_out ##1 acc_done_out);
endmodule

bind pmc_top pmc_sva #(.NB(NB)) sva_u (.*);

// [dv/pmc_mem_model.sv]
/* Passive model of the external memories hanging on the bank selects.
   Assumes active-low quarter-phase select vectors, four bits per bank. */
module pmc_mem_model #(
   parameter int NB = 8
) (
   input wire logic ref_clk_in,
   input wire logic clr_in,
   input wire logic [NB*4-1:0] select_n_in,
   output logic [NB-1:0] banks_hit_out
);
   // ==========================================================================
   // select capture
   // any quarter phase
   always_ff @(posedge ref_clk_in) begin
      for (int g = 0; g < NB; g++) begin
         if (clr_in) begin
            banks_hit_out[g] <= 1'h0;
         end else if (!(&select_n_in[g*4+:4])) begin
            banks_hit_out[g] <= 1'h1;
         end
      end
   end
endmodule

// [dv/tb_top.sv]
/* Testbench for pmc_top: boot decode, bank match, errors and sequencer runs.
   Assumes the design and pmc_pkg are compiled first; one 100 MHz clock. */
`include "pmc_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;
   // ==========================================================================
   // stimulus and design
   logic ref_clk_in = 1'h0, nrst_in = 1'h0, acc_req_in = 1'h0, acc_write_in = 1'h0;
   logic acc_burst_in = 1'h0, refresh_req_in = 1'h0, exception_in = 1'h0, clr = 1'h0;
   logic boot_reprog_in = 1'h0, bus_monitor_en_in = 1'h1, pat_we_in = 1'h0;
   logic [2:0] refresh_bank_in = 3'h0;
   logic [1:0] boot_port_size_in = `PMC_PS_8;
   pmc_addr_t acc_addr_in = 32'h0, mem_addr_out;
   logic [135:0] bank_base_in = 136'h0, bank_size_mask_in = 136'h0;
   logic [7:0] bank_valid_in = 8'h0, bank_write_protect_in = 8'h0, precharge_cycles_in = 8'h0;
   logic [15:0] machine_select_field_in = 16'h0, port_size_field_in = 16'h0;
   logic [31:0] wait_state_count_in = 32'h2, pat_data_in = 32'h0, select_phase_bits_n_out;
   logic [3:0] loop_count_in = 4'h3;
   pmc_pat_addr_t pat_addr_in = 6'h0;
   logic acc_ready_out, acc_done_out, port8_out, transfer_ack_out, transfer_error_ack_out;
   logic [15:0] byte_select_lines_n_out;
   logic [13:0] gp_lines_out;
   logic [1:0] row_col_mux_select_out;
   logic [7:0] hit;
   logic [31:0] hs[$];
   logic ha[$];
   logic [13:0] hg[$];
   logic [1:0] hm[$];
   pmc_addr_t hq[$];
   int errors = 0;
   int n_compared = 0;
   pmc_top dut_u (.*);
   pmc_mem_model mem_u (.ref_clk_in(ref_clk_in), .clr_in(clr),
      .select_n_in(select_phase_bits_n_out), .banks_hit_out(hit));
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // ==========================================================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic int nack();
      int n = 0;
      foreach (ha[k]) if (ha[k] === 1'h1) n++;
      return n;
   endfunction
   function automatic int fa();
      int f;
      for (f = 0; f < ha.size(); f++) if (ha[f] === 1'h1) break;
      return f;
   endfunction
   task automatic pat(input logic [5:0] a, input logic [31:0] d);
      pat_addr_in = a;
      pat_data_in = d;
      pat_we_in = 1'h1;
      @(posedge ref_clk_in);
      #1;
   endtask
   // a take shows as busy, an ack or a select; a refusal gives up after 9 cycles
   task automatic acc(input pmc_addr_t a, input logic wr, bu, output logic tk, er);
      tk = 0;
      er = 0;
      hs = {};
      ha = {};
      hg = {};
      hm = {};
      hq = {};
      {acc_addr_in, acc_write_in, acc_burst_in, acc_req_in, clr} = {a, wr, bu, 2'h3};
      for (int i = 0; i < 80; i++) begin
         @(posedge ref_clk_in);
         #1;
         clr = 1'h0;
         er = er | (transfer_error_ack_out === 1'h1);
         if (!tk && (acc_ready_out === 1'h0 || transfer_ack_out === 1'h1 ||
               !(&select_phase_bits_n_out))) tk = 1;
         if (er || (!tk && i == 8)) begin
            acc_req_in = 1'h0;
            return;
         end
         if (tk) begin
            acc_req_in = 1'h0;
            hs.push_back(select_phase_bits_n_out);
            ha.push_back(transfer_ack_out);
            hg.push_back(gp_lines_out);
            hm.push_back(row_col_mux_select_out);
            if (transfer_ack_out === 1'h1) hq.push_back(mem_addr_out);
            if (acc_done_out === 1'h1) return;
         end
      end
      chk(32'h0, 32'h1);
      test_done();
   endtask
   task automatic bank(input int g, input logic [16:0] b, input logic [16:0] m);
      bank_base_in[g*17+:17] = b;
      bank_size_mask_in[g*17+:17] = m;
   endtask
   // ==========================================================================
   // scenarios
   task automatic t_boot();
      logic tk, er;
      int n = 0;
      acc(32'h7000_0000, 1'h0, 1'h0, tk, er);
      chk(hit, 8'h01);
      chk(nack(), 4);
      foreach (hq[j]) chk(hq[j], 32'h7000_0000 + j);
      for (int i = 0; i <= fa() && i < hs.size(); i++) n += !(&hs[i][3:0]);
      chk(n, wait_state_count_in[3:0] + 1);
   endtask
   task automatic cfg();
      bank(0, 17'h0, 17'h1FFFC);
      bank(1, 17'h2000, 17'h1FF00);
      bank(2, 17'h4000, 17'h1FFE0);
      bank(3, 17'h6000, 17'h1FFE0);
      bank(4, 17'h4000, 17'h1FFE0);
      {bank_valid_in, bank_write_protect_in, wait_state_count_in} = {16'h1701, 32'h0};
      machine_select_field_in[3:2] = `PMC_MS_SEQ_A;
      port_size_field_in[1:0] = `PMC_PS_8;
      boot_reprog_in = 1'h1;
      pat(6'h18, 32'h0FFF_FF24);
      boot_reprog_in = 1'h0;
      pat(6'h19, 32'h00F3_FF00);
      pat(6'h1A, 32'hF1FF_FF47);
      pat(`PMC_ENT_BURST_RD, 32'h00FF_FC89);
      pat(`PMC_ENT_SINGLE_WR, (32'(`PMC_ENT_SINGLE_WR) << `PMC_W_GPL_LSB) | 32'h1);
      pat(`PMC_ENT_BURST_WR, (32'(`PMC_ENT_BURST_WR) << `PMC_W_GPL_LSB) | 32'h1);
      pat_we_in = 1'h0;
   endtask
   task automatic t_errs();
      logic tk, er;
      acc(32'h0000_0100, 1'h1, 1'h0, tk, er);
      chk({tk, er, hit}, {2'h1, 8'h00});
      acc(32'h0000_0100, 1'h0, 1'h0, tk, er);
      chk({er, hit, 3'(nack())}, {1'h0, 8'h01, 3'h4});
      acc(32'h2010_0000, 1'h0, 1'h0, tk, er);
      chk({tk, er}, 2'h1);
      acc(32'h3000_0000, 1'h0, 1'h0, tk, er);
      chk({tk, er, hit}, {2'h1, 8'h00});
      bus_monitor_en_in = 1'h0;
      acc(32'h3000_0000, 1'h0, 1'h0, tk, er);
      chk({tk, er}, 2'h0);
      bus_monitor_en_in = 1'h1;
   endtask
   task automatic t_decode();
      logic tk, er;
      pmc_addr_t a[2] = '{32'h2000_0004, 32'h200F_FFFC};
      foreach (a[j]) begin
         acc(a[j], 1'h0, 1'h0, tk, er);
         chk({hit, 2'(nack()), hq[0]}, {8'h04, 2'h1, a[j]});
      end
   endtask
   task automatic t_seq();
      logic tk, er;
      int k = 0;
      acc(32'h1000_0100, 1'h0, 1'h1, tk, er);
      chk(nack(), 32'(loop_count_in) + 1);
      foreach (hq[j]) chk(hq[j], 32'h1000_0100 + 4 * j);
      for (int w = 0; w < 2; w++) begin
         acc(32'h1000_0200, 1'h1, w[0], tk, er);
         chk({hit, hg[fa()]}, {8'h02, 14'(w ? 8'h20 : 8'h00)});
      end
      acc(32'h1000_0040, 1'h0, 1'h0, tk, er);
      while (k < hm.size() && hm[k] !== 2'h2) k++;
      chk({hs[k][7:4], hs[k+1][7:4], hs[k+2][7:4]}, 12'h00F);
      chk(hg[k+1], 32'h00F3_FF00 >> `PMC_W_GPL_LSB);
      chk({ha[k], ha[k+1], 3'(nack())}, 5'h09);
   endtask
   // ==========================================================================
   // main sequence and hang guard
   initial begin
      repeat (8) @(posedge ref_clk_in);
      #1;
      nrst_in = 1'h1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      t_boot();
      cfg();
      t_errs();
      t_decode();
      t_seq();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      chk(32'h0, 32'h1);
      test_done();
   end
endmodule
